// >>> inc/ocp_pkg.sv
package ocp_pkg;
   // Protection mode: report only, latch off, or cycle-by-cycle restore
   typedef enum logic [1:0] {
      OCP_PM_REPORT = 2'h0,
      OCP_PM_LATCH = 2'h1,
      OCP_PM_CBC_LONG = 2'h2,
      OCP_PM_CBC_SHORT = 2'h3
   } ocp_mode_t;
   // Drive state, Gray coded along off -> on -> wait -> on
   typedef enum logic [1:0] {
      OCP_ST_OFF = 2'h0,
      OCP_ST_ON = 2'h1,
      OCP_ST_WAIT = 2'h3
   } ocp_state_t;
   // Limit comparator interrupt mode that arms rising-edge trips
   localparam logic [1:0] OCP_IRQ_MODE_RISE = 2'h3;
   // Limit comparator input modes; bit 1 set means triple input
   localparam logic [1:0] OCP_IN_SINGLE = 2'h0;
   localparam logic [1:0] OCP_IN_DUAL = 2'h1;
   localparam int OCP_IN_TRIPLE_BIT = 1;
   // Event filter width codes and their lengths in clock cycles
   localparam logic [1:0] OCP_FW_OFF = 2'h0;
   localparam logic [1:0] OCP_FW_SHORT = 2'h1;
   localparam logic [1:0] OCP_FW_MID = 2'h2;
   localparam logic [4:0] OCP_FW_SHORT_CYC = 5'h06;
   localparam logic [4:0] OCP_FW_MID_CYC = 5'h0C;
   localparam logic [4:0] OCP_FW_LONG_CYC = 5'h18;
   // External interrupt zero source code for the inverted bus comparator
   localparam logic [2:0] OCP_SRC_BUS_CMP = 3'h7;
   // External interrupt zero edge codes; other codes mean both edges
   localparam logic [1:0] OCP_EDGE_RISE = 2'h0;
   localparam logic [1:0] OCP_EDGE_FALL = 2'h1;
   // Restore intervals in nanoseconds and the default clock rate
   localparam int OCP_RESTORE_LONG_NS = 10000;
   localparam int OCP_RESTORE_SHORT_NS = 5000;
   localparam int OCP_CLK_MHZ = 200;
   // Pin synchroniser lanes: three phase comparators, bus, external line
   localparam int OCP_NUM_PINS = 5;
   localparam int OCP_PIN_BUS = 3;
   localparam int OCP_PIN_EXT = 4;
endpackage

// >>> inc/ocp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ocp_link_if #(parameter int CNT_W = 12);
   logic filtIn;               // Selected trip level before filtering
   logic [1:0] filtWidth;      // Event filter width code
   logic filtOut;              // Filtered trip level
   logic tmrStart;             // Pulse: load and run the restore timer
   logic tmrCancel;            // Pulse: stop the restore timer
   logic [CNT_W-1:0] tmrLen;   // Restore interval in cycles
   logic tmrDone;              // Pulse: restore interval elapsed
   modport filt (input filtIn, input filtWidth, output filtOut);
   modport tmr (input tmrStart, input tmrCancel, input tmrLen, output tmrDone);
endinterface
`default_nettype wire

// >>> design/ocp_event_filter.sv
`timescale 1ns/1ps
`default_nettype none
module ocp_event_filter #(parameter int CNT_W = 5) (
   input wire logic ref_clk,
   input wire logic reset,
   ocp_link_if.filt link
);
   import ocp_pkg::*;
   // Width must hold the longest filter length
   if (CNT_W < 5) begin : g_chk
      $error("ocp_event_filter: CNT_W too small");
   end
   typedef struct packed {
      logic out;            // Accepted level
      logic [CNT_W-1:0] cnt; // Cycles the input has differed
   } ocp_filt_t;
   ocp_filt_t q_reg;
   ocp_filt_t q_next;
   logic [CNT_W-1:0] lenCyc;
   ////////////////////////////////////////////////////////////////
   // Length lookup and hold counter
   always_comb begin
      unique case (link.filtWidth)
         OCP_FW_SHORT: lenCyc = CNT_W'(OCP_FW_SHORT_CYC);
         OCP_FW_MID: lenCyc = CNT_W'(OCP_FW_MID_CYC);
         default: lenCyc = CNT_W'(OCP_FW_LONG_CYC);
      endcase
      q_next = q_reg;
      if (link.filtWidth == OCP_FW_OFF) begin
         // Bypass keeps the held level current for a later switch-on
         q_next.out = link.filtIn;
         q_next.cnt = '0;
      end else if (link.filtIn == q_reg.out) begin
         // Glitch shorter than the width is forgotten
         q_next.cnt = '0;
      end else if (q_reg.cnt == lenCyc - CNT_W'(1)) begin
         q_next.out = link.filtIn; // RULE18
         q_next.cnt = '0;
      end else begin
         q_next.cnt = q_reg.cnt + CNT_W'(1); // RULE8
      end
   end
   // State register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end
   // Filtered level lags by exactly the width; bypass is transparent
   assign link.filtOut = (link.filtWidth == OCP_FW_OFF) ? link.filtIn : q_reg.out; // RULE9
endmodule
`default_nettype wire

// >>> design/ocp_restore_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ocp_restore_timer #(parameter int CNT_W = 12) (
   input wire logic ref_clk,
   input wire logic reset,
   ocp_link_if.tmr link
);
   import ocp_pkg::*;
   // A counter under two bits wide cannot time anything
   if (CNT_W < 2) begin : g_chk
      $error("ocp_restore_timer: CNT_W too small");
   end
   typedef struct packed {
      logic run;             // Interval in progress
      logic [CNT_W-1:0] cnt; // Cycles left
   } ocp_tmr_t;
   ocp_tmr_t q_reg;
   ocp_tmr_t q_next;
   ////////////////////////////////////////////////////////////////
   // Down counter; a new start restarts the interval
   always_comb begin
      q_next = q_reg;
      if (link.tmrStart) begin
         q_next.run = 1'b1;
         q_next.cnt = link.tmrLen; // RULE19
      end else if (link.tmrCancel || link.tmrDone) begin
         q_next.run = 1'b0;
      end else if (q_reg.run) begin
         q_next.cnt = q_reg.cnt - CNT_W'(1);
      end
   end
   // State register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end
   // Done in the last counted cycle, so the owner acts on the next edge
   assign link.tmrDone = q_reg.run && (q_reg.cnt == CNT_W'(1));
endmodule
`default_nettype wire

// >>> design/ocp_protect_logic.sv
// Overview of operation
// RULE1: Over-current event clears drive output enable
// RULE2: Mode 01 switches off and raises request
// RULE3: Mode 00 only raises the request
// RULE4: Select bit picks external interrupt zero source; the code ignores the bit in mode 00 and trips on the limit comparator
// RULE5: Otherwise limit comparator rising edge trips
// RULE6: Input mode: single, dual, triple comparators
// RULE7: Triple mode trips on any phase
// RULE8: Filter widths are 6, 12, 24 cycles
// RULE9: Filtered level lags by the width
// RULE10: Rising limit comparator edge clears enable
// RULE11: Mode 10 restores on wrap or 10us
// RULE12: Mode 11 restores on wrap or 5us
// RULE13: Software disables drive on bus trips
// RULE14: Bus comparator readable and inverted to interrupt
// RULE15: Source code 111 routes bus comparator
// RULE16: Edge code 01 means falling edge
// RULE17: Limit comparator hysteresis is software configurable
// RULE18: Filter passes only fully held levels
// RULE19: Restore intervals counted from clock parameter
`timescale 1ns/1ps
`default_nettype none
module ocp_protect_logic #(
   parameter int CLK_MHZ = ocp_pkg::OCP_CLK_MHZ,
   parameter int CNT_W = 12
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [2:0] limitComparatorPin,
   input wire logic busComparatorPin,
   input wire logic externalInterruptZeroPin,
   input wire ocp_pkg::ocp_mode_t protectMode,
   input wire logic extIrqProtectSelect,
   input wire logic [1:0] extIrqEdgeSelect,
   input wire logic [2:0] extIrqSourceSelect,
   input wire logic [1:0] limitComparatorIrqMode,
   input wire logic [1:0] limitComparatorInputMode,
   input wire logic limitComparatorHysteresis,
   input wire logic limitComparatorEnable,
   input wire logic busComparatorEnable,
   input wire logic [1:0] eventFilterWidth,
   input wire logic driverTimerWrap,
   input wire logic driveEnableSet,
   input wire logic driveEnableClear,
   output logic driveOutputEnable,
   output logic overCurrentIrq,
   output logic extIrqZeroIrq,
   output logic busComparatorOutput,
   output logic limitComparatorOutput,
   output logic limitHysteresisCtrl
);
   import ocp_pkg::*;

   ////////////////////////////////////////////////////////////////
   // Timing derived from the clock rate

   // Fixed intervals; both are whole cycles at any MHz rate
   localparam int LONG_CYC = OCP_RESTORE_LONG_NS * CLK_MHZ / 1000;
   localparam int SHORT_CYC = OCP_RESTORE_SHORT_NS * CLK_MHZ / 1000;
   // Bounds for the off-time checks below
   localparam int SHORT_BOUND = SHORT_CYC;
   localparam int LONG_BOUND = LONG_CYC;

   // The counter must hold the longer interval
   if ((CLK_MHZ < 1) || (LONG_CYC >= (1 << CNT_W))) begin : g_chk
      $error("ocp_protect_logic: CNT_W cannot hold the restore interval");
   end

   ////////////////////////////////////////////////////////////////
   // Module state

   typedef struct packed {
      logic [OCP_NUM_PINS-1:0] sync1;  // First stage, read only by sync2
      logic [OCP_NUM_PINS-1:0] sync2;  // Second stage
      logic [OCP_NUM_PINS-1:0] sync3;  // Third stage
      logic [OCP_NUM_PINS-1:0] clean;  // Level accepted once 2 and 3 agree
      ocp_state_t st;                  // Drive enable state
      logic trigPrev;                  // Filtered trip level, last cycle
      logic extPrev;                   // Raw interrupt zero level, last cycle
      logic ocpIrq;                    // Over-current request pulse
      logic extIrq;                    // Interrupt zero request pulse
      logic busOut;                    // Bus comparator status
      logic limOut;                    // Limit comparator status
      logic hys;                       // Hysteresis control to the analog side
      logic [CNT_W-1:0] offCnt;        // Cycles spent in the restore wait
   } ocp_top_t;

   ocp_top_t q_reg;
   ocp_top_t q_next;

   // Internal carrier to the filter and timer
   ocp_link_if #(.CNT_W(CNT_W)) link ();

   logic limitLevel;      // Combined limit comparator level
   logic busLevel;        // Enabled bus comparator level
   logic extSrcLevel;     // Selected interrupt zero source level
   logic useExt;          // Trip taken from interrupt zero
   logic trip;            // Over-current event this cycle
   logic extEdge;         // Interrupt zero edge on the raw source
   logic autoOff;         // Trip that must switch the drive off

   ////////////////////////////////////////////////////////////////
   // Edge match for interrupt zero edge codes

   function automatic logic edgeHit(input logic prev, input logic cur, input logic [1:0] sel);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         OCP_EDGE_RISE: hit = !prev && cur;
         OCP_EDGE_FALL: hit = prev && !cur; // RULE16
         default: hit = prev != cur;
      endcase
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////
   // Sub-blocks

   // Event filter on the selected trip level
   ocp_event_filter #(.CNT_W(5)) u_filter (
      .ref_clk(ref_clk),
      .reset(reset),
      .link(link.filt)
   );

   // Restore interval timer
   ocp_restore_timer #(.CNT_W(CNT_W)) u_timer (
      .ref_clk(ref_clk),
      .reset(reset),
      .link(link.tmr)
   );

   ////////////////////////////////////////////////////////////////
   // Source selection and trip detection

   always_comb begin
      // Comparator combine; a disabled comparator never trips
      if (!limitComparatorEnable) begin
         limitLevel = 1'b0;
      end else if (limitComparatorInputMode[OCP_IN_TRIPLE_BIT]) begin
         limitLevel = |q_reg.clean[2:0]; // RULE7
      end else if (limitComparatorInputMode == OCP_IN_DUAL) begin
         limitLevel = q_reg.clean[0] || q_reg.clean[1]; // RULE6
      end else begin
         limitLevel = q_reg.clean[0]; // RULE6
      end
      busLevel = busComparatorEnable && q_reg.clean[OCP_PIN_BUS];
      // Bus comparator reaches interrupt zero inverted
      if (extIrqSourceSelect == OCP_SRC_BUS_CMP) begin
         extSrcLevel = !busLevel; // RULE15
      end else begin
         extSrcLevel = q_reg.clean[OCP_PIN_EXT];
      end
      // Interrupt zero only serves protection in a nonzero mode
      useExt = extIrqProtectSelect && (protectMode != OCP_PM_REPORT); // RULE4
      link.filtIn = useExt ? extSrcLevel : limitLevel;
      link.filtWidth = eventFilterWidth;
      extEdge = edgeHit(q_reg.extPrev, extSrcLevel, extIrqEdgeSelect); // RULE16
   end

   ////////////////////////////////////////////////////////////////
   // Next state: synchronisers, drive state, requests, timer control

   always_comb begin
      // Trip decode lives here, apart from the filter input, so the filter
      // bypass cannot close a loop through a single process
      // Trip on the filtered level; the edge comes from the source rules
      if (useExt) begin
         trip = edgeHit(q_reg.trigPrev, link.filtOut, extIrqEdgeSelect); // RULE4
      end else begin
         trip = (limitComparatorIrqMode == OCP_IRQ_MODE_RISE) && !q_reg.trigPrev && link.filtOut; // RULE5
      end
      // Report-only mode never touches the drive
      autoOff = trip && (protectMode != OCP_PM_REPORT); // RULE3
      q_next = q_reg;
      link.tmrStart = 1'b0;
      link.tmrCancel = 1'b0;
      link.tmrLen = (protectMode == OCP_PM_CBC_SHORT) ? CNT_W'(SHORT_CYC) : CNT_W'(LONG_CYC);
      // Pins cross into the clock domain through three flops
      q_next.sync1 = {externalInterruptZeroPin, busComparatorPin, limitComparatorPin};
      q_next.sync2 = q_reg.sync1;
      q_next.sync3 = q_reg.sync2;
      // A change counts only once the last two stages agree
      for (int i = 0; i < OCP_NUM_PINS; i++) begin
         if (q_reg.sync2[i] == q_reg.sync3[i]) begin
            q_next.clean[i] = q_reg.sync3[i];
         end
      end
      q_next.trigPrev = link.filtOut;
      q_next.extPrev = extSrcLevel;
      // The request fires in every mode, even when the drive stays on
      q_next.ocpIrq = trip; // RULE2 RULE3
      q_next.extIrq = extEdge;
      // Status readback; the bus comparator switches the drive off only when routed through interrupt zero source 111
      q_next.busOut = busLevel; // RULE14 RULE13
      q_next.limOut = limitLevel;
      q_next.hys = limitComparatorHysteresis; // RULE17
      // Drive enable state machine
      unique case (q_reg.st)
         OCP_ST_OFF: begin
            // Only software brings the drive up from off
            if (driveEnableSet && !autoOff) begin
               q_next.st = OCP_ST_ON;
            end
         end
         OCP_ST_ON: begin
            if (autoOff && protectMode[1]) begin
               // Cycle-by-cycle modes wait for a restore
               q_next.st = OCP_ST_WAIT; // RULE10
               link.tmrStart = 1'b1;
            end else if (autoOff) begin
               q_next.st = OCP_ST_OFF; // RULE1 RULE2
            end else if (driveEnableClear) begin
               q_next.st = OCP_ST_OFF;
            end
         end
         OCP_ST_WAIT: begin
            if (driveEnableClear || !protectMode[1]) begin
               // Software off, or mode left cycle-by-cycle
               q_next.st = OCP_ST_OFF;
               link.tmrCancel = 1'b1;
            end else if (autoOff) begin
               // A fresh trip while off restarts the interval
               link.tmrStart = 1'b1;
            end else if (driverTimerWrap || link.tmrDone) begin
               q_next.st = OCP_ST_ON; // RULE11 RULE12
               link.tmrCancel = 1'b1;
            end
         end
         default: begin
            // Unused code recovers to safe off
            q_next.st = OCP_ST_OFF;
         end
      endcase
      // Off-time counter, read only by the checks
      if (link.tmrStart) begin
         q_next.offCnt = CNT_W'(1);
      end else if (q_reg.st == OCP_ST_WAIT) begin
         q_next.offCnt = q_reg.offCnt + CNT_W'(1);
      end else begin
         q_next.offCnt = '0;
      end
   end

   // State register; reset leaves the drive off
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q_reg <= '0;
         q_reg.st <= OCP_ST_OFF;
      end else begin
         q_reg <= q_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs, all from flops

   assign driveOutputEnable = (q_reg.st == OCP_ST_ON);
   assign overCurrentIrq = q_reg.ocpIrq;
   assign extIrqZeroIrq = q_reg.extIrq;
   assign busComparatorOutput = q_reg.busOut;
   assign limitComparatorOutput = q_reg.limOut;
   assign limitHysteresisCtrl = q_reg.hys;

   ////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_trip_drive_off: assert property ( // RULE1
      driveOutputEnable && autoOff |=> !driveOutputEnable)
      else $error("drive stayed on after a trip");

   a_latch_mode_irq: assert property ( // RULE2
      driveOutputEnable && trip && protectMode == OCP_PM_LATCH
      |=> overCurrentIrq && !driveOutputEnable ##1 (!driveOutputEnable || $past(driveEnableSet)))
      else $error("latch mode trip missed off or request");

   a_report_keeps_drive: assert property ( // RULE3
      driveOutputEnable && trip && protectMode == OCP_PM_REPORT && !driveEnableClear
      |=> driveOutputEnable && overCurrentIrq)
      else $error("report mode trip changed the drive");

   a_ext_source_trip: assert property ( // RULE4
      useExt && eventFilterWidth == OCP_FW_OFF && $past(eventFilterWidth) == OCP_FW_OFF
      && edgeHit($past(extSrcLevel), extSrcLevel, extIrqEdgeSelect) && $stable(useExt)
      |=> overCurrentIrq)
      else $error("interrupt zero edge did not trip");

   a_limit_rise_trip: assert property ( // RULE5
      !useExt && $stable(useExt) && limitComparatorIrqMode == OCP_IRQ_MODE_RISE
      && $rose(link.filtOut) |=> overCurrentIrq)
      else $error("limit comparator rise did not trip");

   a_triple_any_phase: assert property ( // RULE7
      limitComparatorEnable && limitComparatorInputMode[OCP_IN_TRIPLE_BIT] && q_reg.clean[2]
      |=> limitComparatorOutput)
      else $error("triple mode ignored a phase");

   a_single_one_phase: assert property ( // RULE6
      limitComparatorInputMode == OCP_IN_SINGLE && !q_reg.clean[0] |=> !limitComparatorOutput)
      else $error("single mode used another phase");

   a_filter_lag_six: assert property ( // RULE9
      eventFilterWidth == OCP_FW_SHORT && !link.filtOut && $rose(link.filtIn)
      ##1 (link.filtIn && eventFilterWidth == OCP_FW_SHORT)[*5]
      |=> $rose(link.filtOut))
      else $error("filter lag not six cycles");

   a_filter_held_level: assert property ( // RULE18
      eventFilterWidth == OCP_FW_SHORT && $past(eventFilterWidth, 6) == OCP_FW_SHORT
      && $stable(eventFilterWidth) && $rose(link.filtOut)
      |-> $past(link.filtIn) && $past(link.filtIn, 3) && $past(link.filtIn, 6))
      else $error("filter passed a short pulse");

   a_wrap_restores: assert property ( // RULE11
      q_reg.st == OCP_ST_WAIT && driverTimerWrap && !autoOff && !driveEnableClear
      && protectMode[1] |=> driveOutputEnable)
      else $error("timer wrap did not restore drive");

   a_long_off_time: assert property ( // RULE11
      q_reg.st == OCP_ST_WAIT && protectMode == OCP_PM_CBC_LONG |-> q_reg.offCnt <= CNT_W'(LONG_BOUND))
      else $error("long restore interval exceeded");

   a_short_off_time: assert property ( // RULE12
      q_reg.st == OCP_ST_WAIT && protectMode == OCP_PM_CBC_SHORT |-> q_reg.offCnt <= CNT_W'(SHORT_BOUND))
      else $error("short restore interval exceeded");

   a_bus_inverted_src: assert property ( // RULE14
      $past(extIrqSourceSelect) == OCP_SRC_BUS_CMP && $past(extIrqSourceSelect, 2) == OCP_SRC_BUS_CMP
      && $past(extIrqEdgeSelect) == OCP_EDGE_FALL && $rose(busComparatorOutput) |-> extIrqZeroIrq)
      else $error("bus comparator not inverted to interrupt zero");

   a_falling_edge_irq: assert property ( // RULE16
      extIrqEdgeSelect == OCP_EDGE_FALL && $fell(extSrcLevel) |=> extIrqZeroIrq)
      else $error("falling edge missed on interrupt zero");

endmodule
`default_nettype wire

// >>> testbench/ocp_comparator_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Analog current comparators as the logic sees them: plain levels
// that change off the clock grid, so the pin synchroniser is used
module ocp_comparator_model (
   input wire logic [2:0] phaseOver,
   input wire logic busOver,
   input wire logic extLevel,
   output logic [2:0] limitPin,
   output logic busPin,
   output logic extPin
);
   // Propagation delay keeps pin edges away from ref_clk edges
   localparam realtime PROP = 1.3ns;
   // Phase comparators, bus comparator and the external line
   assign #PROP limitPin = phaseOver;
   assign #PROP busPin = busOver;
   assign #PROP extPin = extLevel;
endmodule
`default_nettype wire

// >>> testbench/test_ocp_protect_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_ocp_protect_logic;
   import ocp_pkg::*;
   logic ref_clk = 1'h0, reset = 1'h1;
   logic [2:0] phaseOver = 3'h0, limitPin, srcSel = 3'h0;
   logic busOver = 1'h0, extLevel = 1'h0, busPin, extPin;
   ocp_mode_t protectMode = OCP_PM_REPORT;
   logic extSel = 1'h0, hys = 1'h0, wrap = 1'h0, setP = 1'h0, clrP = 1'h0, limEn = 1'h1;
   logic [1:0] edgeSel = 2'h0, irqMode = OCP_IRQ_MODE_RISE, inMode = OCP_IN_SINGLE, filtW = OCP_FW_OFF;
   logic drive, ocIrq, extIrq, busOut, limOut, hysOut;
   int fail_count = 0, samples_checked = 0, irqCount = 0, extCount = 0, lat, off, n, k;
   ////////////////////////////////////////////////////////////
   // 200 MHz reference clock
   always #2.5 ref_clk = ~ref_clk;
   // Far side: comparators feeding the pins
   ocp_comparator_model cmpModel (.phaseOver(phaseOver), .busOver(busOver), .extLevel(extLevel),
      .limitPin(limitPin), .busPin(busPin), .extPin(extPin));
   // Slow clock figure keeps restore intervals at 100 and 50 cycles
   ocp_protect_logic #(.CLK_MHZ(10), .CNT_W(12)) DUT (.ref_clk(ref_clk), .reset(reset),
      .limitComparatorPin(limitPin), .busComparatorPin(busPin), .externalInterruptZeroPin(extPin),
      .protectMode(protectMode), .extIrqProtectSelect(extSel), .extIrqEdgeSelect(edgeSel),
      .extIrqSourceSelect(srcSel), .limitComparatorIrqMode(irqMode), .limitComparatorInputMode(inMode),
      .limitComparatorHysteresis(hys), .limitComparatorEnable(limEn), .busComparatorEnable(1'h1),
      .eventFilterWidth(filtW), .driverTimerWrap(wrap), .driveEnableSet(setP), .driveEnableClear(clrP),
      .driveOutputEnable(drive), .overCurrentIrq(ocIrq), .extIrqZeroIrq(extIrq),
      .busComparatorOutput(busOut), .limitComparatorOutput(limOut), .limitHysteresisCtrl(hysOut));
   ////////////////////////////////////////////////////////////
   // Request pulses stand one cycle, so each settled sample sees one
   always @(negedge ref_clk) begin
      if (ocIrq === 1'h1) irqCount++;
      if (extIrq === 1'h1) extCount++;
   end
   // Inputs move only on falling edges
   task automatic step(input int c);
      repeat (c) @(negedge ref_clk);
   endtask
   task automatic chkBit(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s is %b", $time, what, got);
      end
   endtask
   task automatic chkCnt(input int got, input int exp, input string what);
      samples_checked++;
      if (got != exp) begin
         fail_count++;
         $display("unexpected at %0t: %s is %0d, not %0d", $time, what, got, exp);
      end
   endtask
   // One-cycle software or timer pulse
   task automatic pulse(ref logic s);
      s = 1'h1;
      step(1);
      s = 1'h0;
   endtask
   // Raise comparator levels and count cycles to the request, capped at 60
   task automatic trip(input logic [2:0] ph, input logic b, input logic e);
      phaseOver = ph;
      busOver = b;
      extLevel = e;
      lat = 0;
      while (ocIrq !== 1'h1 && lat < 60) begin
         step(1);
         lat++;
      end
   endtask
   // Drop all levels and wait out synchroniser plus longest filter
   task automatic idle();
      phaseOver = 3'h0;
      busOver = 1'h0;
      extLevel = 1'h0;
      step(40);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Whole run is under two thousand cycles; this margin is ample
   initial begin
      #100000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      step(6);
      reset = 1'h0;
      step(1);
      chkBit(drive, 1'h0, "drive after reset");
      // Latch-off mode: trip, request and drive cleared
      protectMode = OCP_PM_LATCH;
      pulse(setP);
      chkBit(drive, 1'h1, "software set");
      trip(3'h1, 1'h0, 1'h0);
      chkCnt(lat, 5, "trip latency");
      chkBit(drive, 1'h0, "latched off");
      idle();
      chkBit(drive, 1'h0, "stays off");
      // Report mode keeps drive on
      pulse(setP);
      protectMode = OCP_PM_REPORT;
      trip(3'h1, 1'h0, 1'h0);
      chkCnt(lat, 5, "report request");
      chkBit(drive, 1'h1, "report drive");
      idle();
      // Limit trips are armed only by interrupt mode 11
      irqMode = 2'h2;
      trip(3'h1, 1'h0, 1'h0);
      chkCnt(lat, 60, "unarmed limit");
      irqMode = OCP_IRQ_MODE_RISE;
      idle();
      // A disabled limit comparator never trips
      limEn = 1'h0;
      trip(3'h1, 1'h0, 1'h0);
      chkCnt(lat, 60, "disabled limit");
      chkBit(limOut, 1'h0, "disabled level");
      idle();
      limEn = 1'h1;
      // Every input mode against every phase
      for (int im = 0; im < 4; im++) begin
         for (int ph = 0; ph < 3; ph++) begin
            inMode = im[1:0];
            trip(3'h1 << ph, 1'h0, 1'h0);
            chkBit(lat == 5, ph == 0 || (ph == 1 && im != 0) || (ph == 2 && im > 1), "input mode");
            chkBit(limOut, lat == 5, "limit level");
            idle();
         end
      end
      inMode = OCP_IN_SINGLE;
      // Filter lag and rejection of one-cycle-short pulses
      for (int fw = 1; fw < 4; fw++) begin
         n = 6 << (fw - 1);
         filtW = fw[1:0];
         trip(3'h1, 1'h0, 1'h0);
         chkCnt(lat, 5 + n, "filter lag");
         idle();
         k = irqCount;
         phaseOver = 3'h1;
         step(n - 1);
         idle();
         chkCnt(irqCount, k, "short pulse");
      end
      filtW = OCP_FW_OFF;
      // Cycle-by-cycle restore after the fixed interval
      pulse(setP);
      for (int m = 2; m < 4; m++) begin
         protectMode = ocp_mode_t'(m[1:0]);
         trip(3'h1, 1'h0, 1'h0);
         chkBit(drive, 1'h0, "rising clears");
         phaseOver = 3'h0;
         off = 0;
         while (drive !== 1'h1 && off < 300) begin
            step(1);
            off++;
         end
         chkCnt(off, m == 2 ? 100 : 50, "off time");
      end
      // Timer wrap restores early
      protectMode = OCP_PM_CBC_LONG;
      trip(3'h1, 1'h0, 1'h0);
      phaseOver = 3'h0;
      step(10);
      pulse(wrap);
      chkBit(drive, 1'h1, "wrap restore");
      // Inverted bus comparator through interrupt zero, falling edge
      protectMode = OCP_PM_LATCH;
      extSel = 1'h1;
      srcSel = OCP_SRC_BUS_CMP;
      edgeSel = OCP_EDGE_FALL;
      step(10);
      k = extCount;
      trip(3'h0, 1'h1, 1'h0);
      chkCnt(lat, 5, "bus via interrupt");
      chkBit(drive, 1'h0, "interrupt trip");
      chkBit(busOut, 1'h1, "bus readable");
      idle();
      chkCnt(extCount, k + 1, "falling only");
      // External pin, rising edge
      pulse(setP);
      srcSel = 3'h0;
      edgeSel = OCP_EDGE_RISE;
      step(10);
      trip(3'h0, 1'h0, 1'h1);
      chkCnt(lat, 5, "pin rising");
      idle();
      // Edge code 10 takes both edges of the source
      edgeSel = 2'h2;
      k = extCount;
      extLevel = 1'h1;
      step(10);
      extLevel = 1'h0;
      step(10);
      chkCnt(extCount, k + 2, "both edges");
      // Bus comparator alone never cuts drive; software does it
      extSel = 1'h0;
      pulse(setP);
      busOver = 1'h1;
      step(10);
      chkBit(drive, 1'h1, "bus no auto-off");
      pulse(clrP);
      chkBit(drive, 1'h0, "software off");
      busOver = 1'h0;
      hys = 1'h1;
      step(2);
      chkBit(hysOut, 1'h1, "hysteresis");
      tally_and_finish();
   end
endmodule
`default_nettype wire
